// File: include/adc_host_regs.vh
`ifndef ADC_HOST_REGS_VH
`define ADC_HOST_REGS_VH

// ----------------------------------------
// configuration word layout
// ----------------------------------------
`define CFG_WIDTH 13
`define CFG_RESET 13'h0100
`define CFG_ROUTE_HI 3
`define CFG_ROUTE_LO 0
`define CFG_ROUTE_SE_BIT 3
`define CFG_ACQ_HI 5
`define CFG_ACQ_LO 4
`define CFG_CLAMP_BIT 6
`define CFG_UPPER_PTR_BIT 7
`define CFG_TRIGGER_BIT 8
`define CFG_CMD_HI 11
`define CFG_CMD_LO 9
`define CFG_BUS_WIDTH_BIT 12

// ----------------------------------------
// result word layout
// ----------------------------------------
`define RES_WIDTH 13
`define RES_RESET 13'h0000
`define RES_SIGN_BIT 12

// ----------------------------------------
// bus layout
// ----------------------------------------
`define BUS_WIDTH 13
`define BYTE_WIDTH 8
`define UPPER_CFG_BITS 5

// ----------------------------------------
// commands
// ----------------------------------------
`define CMD_STANDBY 3'h0
`define CMD_FULL_CAL 3'h1
`define CMD_AUTO_ZERO 3'h2
`define CMD_IDLE_RESET 3'h3
`define CMD_START 3'h4

// ----------------------------------------
// acquisition lengths in converter clocks
// ----------------------------------------
`define ACQ_CODE0_CLOCKS 7'h09
`define ACQ_CODE1_CLOCKS 7'h0f
`define ACQ_CODE2_CLOCKS 7'h2f
`define ACQ_CODE3_CLOCKS 7'h4f
`define ACQ_COUNT_WIDTH 7

// ----------------------------------------
// multiplexer output codes
// ----------------------------------------
`define ROUTE_PSEUDO_GROUND 4'h8

`endif

// File: rtl/adc_pin_sync.v
// ----------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------
module adc_pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] pinIn,
	output wire [WIDTH-1:0] pinSync
);
	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;

	// first stage feeds only the second stage
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_q <= RESET_VAL;
			stage2_q <= RESET_VAL;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
		end
	end

	assign pinSync = stage2_q;
endmodule

// File: rtl/adc_host_config_port.v
// Summary of operation
// - all writes reach configuration word, never readable
// - configuration word resets to 0x0100
// - bits 3..0 choose pair or single-ended routing
// - acquisition length 9, 15, 47 or 79
// - clamp bit turns negative results into zero
// - upper pointer steers next byte, then clears
// - wide bus ignores pointer, whole word writes
// - trigger bit set: sync rising edge converts
// - trigger bit clear: sync out high converting
// - command field decode, resets to standby
// - start: convert after count or sync edge
// - bus width bit picks 8 or 13 pins
// - every read returns the result word
// - result sign bit 12, magnitude 11..0
// - upper read byte filled with sign copies
// - 8-bit reads: lower byte then upper byte
// - 13-bit mode: single cycle read and write
// - strap selects falling or rising write edge
// - drive bus only during chip select and read
`include "adc_host_regs.vh"

module adc_host_config_port (
	input wire clk,
	input wire rst,
	input wire chipSelectN,
	input wire readStrobeN,
	input wire writeStrobeN,
	input wire writeEdgeStrap,
	input wire [`BUS_WIDTH-1:0] busPinsIn,
	output reg [`BUS_WIDTH-1:0] busPinsOut,
	output reg [`BUS_WIDTH-1:0] busPinsOe,
	input wire syncPinIn,
	output reg syncPinOut,
	output reg syncPinOe,
	input wire [`RES_WIDTH-1:0] coreResult,
	input wire coreDone,
	output reg convStart,
	output reg [3:0] routePositiveOut,
	output reg [3:0] routeNegativeOut,
	output reg [2:0] commandCode,
	output reg commandWritten,
	output reg [`ACQ_COUNT_WIDTH-1:0] acquisitionLength,
	output reg converting
);
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	localparam [1:0] SEQ_IDLE = 2'h0;
	localparam [1:0] SEQ_ACQUIRE = 2'h1;
	localparam [1:0] SEQ_WAIT_SYNC = 2'h2;
	localparam [1:0] SEQ_CONVERT = 2'h3;

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	function [`ACQ_COUNT_WIDTH-1:0] acqClocks;
		input [1:0] code;
		begin
			case (code)
				2'h0: acqClocks = `ACQ_CODE0_CLOCKS;
				2'h1: acqClocks = `ACQ_CODE1_CLOCKS;
				2'h2: acqClocks = `ACQ_CODE2_CLOCKS;
				default: acqClocks = `ACQ_CODE3_CLOCKS;
			endcase
		end
	endfunction

	function [3:0] routePos;
		input [3:0] code;
		begin
			if (code[`CFG_ROUTE_SE_BIT]) begin
				routePos = {1'b0, code[2:0]};
			end else begin
				routePos = {1'b0, code[2:0]};
			end
		end
	endfunction

	function [3:0] routeNeg;
		input [3:0] code;
		begin
			if (code[`CFG_ROUTE_SE_BIT]) begin
				routeNeg = `ROUTE_PSEUDO_GROUND;
			end else begin
				// partner of the pair: flip the polarity bit
				routeNeg = {1'b0, code[2:1], ~code[0]};
			end
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire [`BUS_WIDTH+4:0] pinsSync;
	wire csSyncN;
	wire rdSyncN;
	wire wrSyncN;
	wire syncPinSync;
	wire strapSync;
	wire [`BUS_WIDTH-1:0] dataSync;

	adc_pin_sync #(
		.WIDTH(`BUS_WIDTH + 5),
		.RESET_VAL({5'h0e, {`BUS_WIDTH{1'b0}}})
	) pinSyncInst (
		.clk(clk),
		.rst(rst),
		.pinIn({writeEdgeStrap, chipSelectN, readStrobeN, writeStrobeN, syncPinIn,
			busPinsIn}),
		.pinSync(pinsSync)
	);

	assign strapSync = pinsSync[`BUS_WIDTH+4];
	assign csSyncN = pinsSync[`BUS_WIDTH+3];
	assign rdSyncN = pinsSync[`BUS_WIDTH+2];
	assign wrSyncN = pinsSync[`BUS_WIDTH+1];
	assign syncPinSync = pinsSync[`BUS_WIDTH];
	assign dataSync = pinsSync[`BUS_WIDTH-1:0];

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	reg [`CFG_WIDTH-1:0] cfg_q;
	reg [`CFG_WIDTH-1:0] cfg_d;
	reg [`RES_WIDTH-1:0] result_q;
	reg [`RES_WIDTH-1:0] result_d;
	reg [1:0] strapAge_q;
	reg strapFalling_q;
	reg wrPrevN_q;
	reg rdPrevN_q;
	reg syncPrev_q;
	reg [`BUS_WIDTH-1:0] dataHeld_q;
	reg readUpper_q;
	reg readUpper_d;
	reg [1:0] seq_q;
	reg [1:0] seq_d;
	reg [`ACQ_COUNT_WIDTH-1:0] acqCount_q;
	reg [`ACQ_COUNT_WIDTH-1:0] acqCount_d;
	reg startConv_d;

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	wire selected = ~csSyncN;
	wire wrFell = wrPrevN_q & ~wrSyncN;
	wire wrRose = ~wrPrevN_q & wrSyncN;
	wire rdRose = ~rdPrevN_q & rdSyncN;
	wire writeTaken = selected & (strapFalling_q ? wrFell : wrRose);
	// rising-edge capture uses data held while the strobe was low
	wire [`BUS_WIDTH-1:0] writeData = strapFalling_q ? dataSync : dataHeld_q;
	wire readDone = selected & rdRose;
	wire syncRose = syncPinSync & ~syncPrev_q;
	wire wideBus = cfg_q[`CFG_BUS_WIDTH_BIT];
	wire triggered = cfg_q[`CFG_TRIGGER_BIT];
	wire readActive = ~csSyncN & ~rdSyncN;

	// ----------------------------------------
	// configuration write path
	// ----------------------------------------
	always @* begin
		cfg_d = cfg_q;
		if (writeTaken) begin
			if (wideBus) begin
				cfg_d = writeData;
			end else if (cfg_q[`CFG_UPPER_PTR_BIT]) begin
				cfg_d[`CFG_WIDTH-1:`BYTE_WIDTH] = writeData[`UPPER_CFG_BITS-1:0];
				cfg_d[`CFG_UPPER_PTR_BIT] = 1'b0;
			end else begin
				cfg_d[`BYTE_WIDTH-1:0] = writeData[`BYTE_WIDTH-1:0];
			end
		end
	end

	// ----------------------------------------
	// read byte selector
	// ----------------------------------------
	always @* begin
		readUpper_d = readUpper_q;
		if (wideBus) begin
			readUpper_d = 1'b0;
		end else if (readDone) begin
			readUpper_d = ~readUpper_q;
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	wire startWritten = writeTaken & (cfg_d[`CFG_CMD_HI:`CFG_CMD_LO] == `CMD_START);
	wire leaveStart = writeTaken & (cfg_d[`CFG_CMD_HI:`CFG_CMD_LO] != `CMD_START);

	always @* begin
		seq_d = seq_q;
		acqCount_d = acqCount_q;
		startConv_d = 1'b0;
		case (seq_q)
			SEQ_IDLE: begin
				if (startWritten) begin
					if (cfg_d[`CFG_TRIGGER_BIT]) begin
						seq_d = SEQ_WAIT_SYNC;
					end else begin
						seq_d = SEQ_ACQUIRE;
						acqCount_d = acqClocks(cfg_d[`CFG_ACQ_HI:`CFG_ACQ_LO]);
					end
				end
			end
			SEQ_ACQUIRE: begin
				if (leaveStart) begin
					seq_d = SEQ_IDLE;
				end else if (acqCount_q == {{(`ACQ_COUNT_WIDTH-1){1'b0}}, 1'b1}) begin
					seq_d = SEQ_CONVERT;
					startConv_d = 1'b1;
				end else begin
					acqCount_d = acqCount_q - {{(`ACQ_COUNT_WIDTH-1){1'b0}}, 1'b1};
				end
			end
			SEQ_WAIT_SYNC: begin
				if (leaveStart) begin
					seq_d = SEQ_IDLE;
				end else if (syncRose) begin
					seq_d = SEQ_CONVERT;
					startConv_d = 1'b1;
				end
			end
			SEQ_CONVERT: begin
				if (coreDone) begin
					if (cfg_q[`CFG_CMD_HI:`CFG_CMD_LO] != `CMD_START) begin
						seq_d = SEQ_IDLE;
					end else if (triggered) begin
						seq_d = SEQ_WAIT_SYNC;
					end else begin
						seq_d = SEQ_ACQUIRE;
						acqCount_d = acqClocks(cfg_q[`CFG_ACQ_HI:`CFG_ACQ_LO]);
					end
				end
			end
			default: begin
				seq_d = SEQ_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// result capture
	// ----------------------------------------
	always @* begin
		result_d = result_q;
		if (seq_q == SEQ_CONVERT && coreDone) begin
			if (cfg_q[`CFG_CLAMP_BIT] && coreResult[`RES_SIGN_BIT]) begin
				result_d = {`RES_WIDTH{1'b0}};
			end else begin
				result_d = coreResult;
			end
		end
	end

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	reg [`BUS_WIDTH-1:0] readData;

	always @* begin
		if (wideBus) begin
			readData = result_q;
		end else if (readUpper_q) begin
			readData = {{(`BUS_WIDTH-`BYTE_WIDTH){1'b0}},
				{(`BYTE_WIDTH-`UPPER_CFG_BITS){result_q[`RES_SIGN_BIT]}},
				result_q[`RES_WIDTH-1:`BYTE_WIDTH]};
		end else begin
			readData = {{(`BUS_WIDTH-`BYTE_WIDTH){1'b0}},
				result_q[`BYTE_WIDTH-1:0]};
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= `CFG_RESET;
			result_q <= `RES_RESET;
			strapAge_q <= 2'h0;
			strapFalling_q <= 1'b0;
			wrPrevN_q <= 1'b1;
			rdPrevN_q <= 1'b1;
			syncPrev_q <= 1'b0;
			dataHeld_q <= {`BUS_WIDTH{1'b0}};
			readUpper_q <= 1'b0;
			seq_q <= SEQ_IDLE;
			acqCount_q <= {`ACQ_COUNT_WIDTH{1'b0}};
		end else begin
			// strap caught once the synchroniser holds the pin level
			if (strapAge_q != 2'h3) begin
				strapAge_q <= strapAge_q + 2'h1;
			end
			if (strapAge_q == 2'h2) begin
				strapFalling_q <= strapSync;
			end
			cfg_q <= cfg_d;
			result_q <= result_d;
			wrPrevN_q <= wrSyncN;
			rdPrevN_q <= rdSyncN;
			syncPrev_q <= syncPinSync;
			if (!wrSyncN) begin
				dataHeld_q <= dataSync;
			end
			readUpper_q <= readUpper_d;
			seq_q <= seq_d;
			acqCount_q <= acqCount_d;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < `BUS_WIDTH; i = i + 1) begin : pinDrive
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					busPinsOe[i] <= 1'b0;
					busPinsOut[i] <= 1'b0;
				end else begin
					// upper pins only join when the wide bus is on
					if (i < `BYTE_WIDTH) begin
						busPinsOe[i] <= readActive;
					end else begin
						busPinsOe[i] <= readActive & wideBus;
					end
					busPinsOut[i] <= readData[i];
				end
			end
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			syncPinOut <= 1'b0;
			syncPinOe <= 1'b0;
			convStart <= 1'b0;
			converting <= 1'b0;
			routePositiveOut <= 4'h0;
			routeNegativeOut <= 4'h1;
			commandCode <= `CMD_STANDBY;
			commandWritten <= 1'b0;
			acquisitionLength <= `ACQ_CODE0_CLOCKS;
		end else begin
			convStart <= startConv_d;
			converting <= (seq_d == SEQ_CONVERT);
			syncPinOe <= ~cfg_d[`CFG_TRIGGER_BIT];
			syncPinOut <= ~cfg_d[`CFG_TRIGGER_BIT] & (seq_d == SEQ_CONVERT);
			routePositiveOut <= routePos(cfg_d[`CFG_ROUTE_HI:`CFG_ROUTE_LO]);
			routeNegativeOut <= routeNeg(cfg_d[`CFG_ROUTE_HI:`CFG_ROUTE_LO]);
			commandCode <= cfg_d[`CFG_CMD_HI:`CFG_CMD_LO];
			commandWritten <= writeTaken;
			acquisitionLength <= acqClocks(cfg_d[`CFG_ACQ_HI:`CFG_ACQ_LO]);
		end
	end
endmodule

// File: verification/adc_host_config_port_assertions.sv
`include "adc_host_regs.vh"

module adc_host_config_port_checker (
	input wire clk,
	input wire rst,
	input wire chipSelectN,
	input wire readStrobeN,
	input wire [`BUS_WIDTH-1:0] busPinsOe,
	input wire syncPinOut,
	input wire syncPinOe,
	input wire coreDone,
	input wire convStart,
	input wire [3:0] routePositiveOut,
	input wire [3:0] routeNegativeOut,
	input wire [2:0] commandCode,
	input wire commandWritten,
	input wire [`ACQ_COUNT_WIDTH-1:0] acquisitionLength,
	input wire converting
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence readIdle;
		(chipSelectN || readStrobeN) [*4];
	endsequence
	sequence convBegin;
		##[0:1] converting;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	bus_release_a: assert property (readIdle |=> busPinsOe == 0)
		else $error("bus driven while not read");
	bus_cause_a: assert property ($rose(busPinsOe[0]) |-> $past(!chipSelectN && !readStrobeN))
		else $error("bus driven without read");
	upper_pins_a: assert property (busPinsOe[12:8] != 0 |-> busPinsOe == 13'h1fff)
		else $error("upper pins driven alone");
	byte_pins_a: assert property (busPinsOe[7:0] == 8'h00 || busPinsOe[7:0] == 8'hff)
		else $error("lower pins split");
	sync_status_a: assert property (syncPinOe |-> syncPinOut == converting)
		else $error("sync output not conversion status");
	sync_input_a: assert property (!syncPinOe |-> !syncPinOut)
		else $error("sync output high while input");
	start_enters_a: assert property (convStart |-> convBegin)
		else $error("start without conversion");
	done_ends_a: assert property (converting && coreDone |=> !converting)
		else $error("conversion outlives done");
	cmd_cause_a: assert property ($changed(commandCode) |-> commandWritten)
		else $error("command changed without write");
	write_pulse_a: assert property (commandWritten |=> !commandWritten)
		else $error("write pulse too long");
	acq_legal_a: assert property (acquisitionLength inside {7'h09, 7'h0f, 7'h2f, 7'h4f})
		else $error("bad acquisition length");
	route_pair_a: assert property (routeNegativeOut == 4'h8 ? !routePositiveOut[3]
		: routeNegativeOut == (routePositiveOut ^ 4'h1))
		else $error("route outputs inconsistent");
endmodule

bind adc_host_config_port adc_host_config_port_checker chk (.clk, .rst, .chipSelectN,
	.readStrobeN, .busPinsOe, .syncPinOut, .syncPinOe, .coreDone, .convStart,
	.routePositiveOut, .routeNegativeOut, .commandCode, .commandWritten,
	.acquisitionLength, .converting);

// File: verification/adc_host_bus_model.sv
module adc_host_bus_model (
	input wire clk,
	input wire [12:0] busPinsOut,
	input wire [12:0] busPinsOe,
	output reg chipSelectN = 1'b1,
	output reg readStrobeN = 1'b1,
	output reg writeStrobeN = 1'b1,
	output wire [12:0] busPinsIn
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [12:0] drv = 13'h0000;
	reg hostOe = 1'b0;
	// undriven pins show the inverse of the last level driven
	assign busPinsIn = (busPinsOe & busPinsOut) | (~busPinsOe & (hostOe ? drv : ~drv));
	task idle(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// data a at the falling strobe edge, b before the rising edge
	task hostWrite(input [12:0] a, input [12:0] b);
		idle(1);
		drv = a;
		hostOe = 1'b1;
		chipSelectN = 1'b0;
		idle(4);
		writeStrobeN = 1'b0;
		idle(4);
		drv = b;
		idle(4);
		writeStrobeN = 1'b1;
		idle(4);
		chipSelectN = 1'b1;
		hostOe = 1'b0;
		idle(3);
	endtask
	task hostRead(output [12:0] q, output [12:0] oe);
		idle(1);
		chipSelectN = 1'b0;
		readStrobeN = 1'b0;
		idle(5);
		q = busPinsIn;
		oe = busPinsOe;
		idle(1);
		readStrobeN = 1'b1;
		idle(4);
		chipSelectN = 1'b1;
		idle(4);
	endtask
endmodule

// File: verification/adc_host_config_port_test.sv
module adc_host_config_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg writeEdgeStrap = 1'b1;
	reg syncPinIn = 1'b0;
	reg coreDone = 1'b0;
	reg [12:0] coreResult = 13'h0000;
	reg [12:0] q, o, r, w;
	reg [31:0] seed = 32'h9ca0c300;
	integer err_total = 0, samples_checked = 0, cycles = 0, gap = 0, gapAt = 0, k, t;
	wire chipSelectN, readStrobeN, writeStrobeN, syncPinOut, syncPinOe;
	wire convStart, commandWritten, converting;
	wire [12:0] busPinsIn, busPinsOut, busPinsOe;
	wire [3:0] routePositiveOut, routeNegativeOut;
	wire [2:0] commandCode;
	wire [6:0] acquisitionLength;
	always #5 clk = ~clk;
	adc_host_config_port uut (.clk, .rst, .chipSelectN, .readStrobeN, .writeStrobeN,
		.writeEdgeStrap, .busPinsIn, .busPinsOut, .busPinsOe, .syncPinIn, .syncPinOut,
		.syncPinOe, .coreResult, .coreDone, .convStart, .routePositiveOut,
		.routeNegativeOut, .commandCode, .commandWritten, .acquisitionLength, .converting);
	adc_host_bus_model host (.clk, .busPinsOut, .busPinsOe, .chipSelectN, .readStrobeN,
		.writeStrobeN, .busPinsIn);
	// core stand-in: result six cycles after each start
	always @(negedge clk) begin
		coreDone <= 1'b0;
		if (convStart) begin
			repeat (6) @(negedge clk);
			coreResult <= r;
			coreDone <= 1'b1;
		end
	end
	// cycles from last write pulse to first start
	always @(posedge clk) begin
		cycles <= cycles + 1;
		gap <= commandWritten ? 1 : gap + 1;
		if (convStart && gapAt == 0)
			gapAt <= gap;
		if (cycles == 30000) begin
			err_total = err_total + 1;
			$display("MISMATCH %0t run timed out", $time);
			complete_run;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [7:0] routeOf(input [3:0] c);
		routeOf = c[3] ? {1'b0, c[2:0], 4'h8} : {1'b0, c[2:0], 1'b0, c[2:1], ~c[0]};
	endfunction
	function [6:0] acqOf(input [1:0] c);
		acqOf = c == 2'h0 ? 7'h09 : c == 2'h1 ? 7'h0f : c == 2'h2 ? 7'h2f : 7'h4f;
	endfunction
	task chkWord(input [12:0] g, input [12:0] e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chkCount(input integer g, input integer e);
		samples_checked = samples_checked + 1;
		if (g != e) begin
			err_total = err_total + 1;
			$display("MISMATCH %0t count %0d expected %0d", $time, g, e);
		end
	endtask
	task resetDut(input strap);
		rst = 1'b1;
		writeEdgeStrap = strap;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	task cfgPair(input [6:0] lo, input [4:0] hi);
		host.hostWrite({5'h00, 1'b1, lo}, {5'h00, 1'b1, lo});
		host.hostWrite({8'h00, hi}, {8'h00, hi});
	endtask
	task pulseSync;
		syncPinIn = 1'b1;
		repeat (20) @(negedge clk);
		syncPinIn = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task readPair(input [12:0] e);
		host.hostRead(q, o);
		chkWord(q[7:0], e[7:0]);
		chkWord(o, 13'h00ff);
		host.hostRead(q, o);
		chkWord(q[7:0], {{3{e[12]}}, e[12:8]});
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetDut(1'b1);
		chkWord(commandCode, 13'h0000);
		chkWord(acquisitionLength, 13'h0009);
		chkWord({routePositiveOut, routeNegativeOut}, routeOf(4'h0));
		chkWord(syncPinOe, 13'h0000);
		readPair(13'h0000);
		$display("test reset done");
		for (k = 0; k < 16; k = k + 1) begin
			seed = xs(seed);
			w = {7'h00, k[1:0] ^ k[3:2], k[3:0]};
			host.hostWrite(w, seed[12:0] & 13'h007f);
			chkWord({routePositiveOut, routeNegativeOut}, routeOf(k[3:0]));
			chkWord(acquisitionLength, acqOf(w[5:4]));
		end
		$display("test routing done");
		cfgPair(7'h40, 5'h09);
		chkWord(commandCode, 13'h0004);
		seed = xs(seed);
		r = seed[12:0] | 13'h1000;
		pulseSync;
		readPair(13'h0000);
		host.hostWrite(13'h0005, 13'h0005);
		chkWord({routePositiveOut, routeNegativeOut}, routeOf(4'h5));
		seed = xs(seed);
		r = seed[12:0] | 13'h1000;
		pulseSync;
		readPair(r);
		host.hostRead(q, o);
		chkWord(q[7:0], r[7:0]);
		$display("test byte access done");
		for (k = 0; k < 4; k = k + 1) begin
			cfgPair(7'h00, {1'b0, k[2:0], 1'b1});
			chkWord(commandCode, k[2:0]);
		end
		for (k = 0; k < 4; k = k + 1) begin
			gapAt = 0;
			cfgPair({1'b0, k[1:0], 4'h0}, 5'h08);
			for (t = 0; t < 200 && gapAt == 0; t = t + 1)
				@(negedge clk);
			chkCount(gapAt, acqOf(k[1:0]));
			chkWord(syncPinOut, 13'h0001);
			chkWord(converting, 13'h0001);
			chkWord(syncPinOe, 13'h0001);
			cfgPair(7'h00, 5'h00);
		end
		$display("test commands done");
		cfgPair(7'h00, 5'h11);
		seed = xs(seed);
		w = {5'h19, 4'h8, seed[3:0]};
		host.hostWrite(w, w);
		host.hostWrite(w ^ 13'h008f, w ^ 13'h008f);
		chkWord({routePositiveOut, routeNegativeOut}, routeOf(~seed[3:0]));
		chkWord(commandCode, 13'h0004);
		r = seed[31:19];
		pulseSync;
		host.hostRead(q, o);
		chkWord(q, r);
		chkWord(o, 13'h1fff);
		$display("test wide bus done");
		resetDut(1'b0);
		host.hostWrite(13'h0003, 13'h000e);
		chkWord({routePositiveOut, routeNegativeOut}, routeOf(4'he));
		$display("test write edge done");
		complete_run;
	end
endmodule
